//--- design/tgs_map.svh
// tgs_map.svh: offsets, bit positions, reset values and timing counts
// for the telegram reception status block; included by bare name.
`ifndef TGS_MAP_SVH
`define TGS_MAP_SVH

// register word addresses on the plain register port
`define TGS_A_CTRL 8'h00
`define TGS_A_SINK 8'h01
`define TGS_A_SRC 8'h02
`define TGS_A_REPLY 8'h03
`define TGS_A_LIVE 8'h04
`define TGS_A_STAT_BASE 8'h10
`define TGS_A_STAT_LAST 8'h1f

// control register fields
`define TGS_CTRL_WRANY_BIT 0

// port status word fields
`define TGS_ST_TIMEOUT 0
`define TGS_ST_TELERR 1
`define TGS_ST_BUSY 2
`define TGS_ST_OVERBAL 3
`define TGS_ST_QUALITY 4
`define TGS_ST_CRC 5
`define TGS_ST_PAGE 6
`define TGS_ST_OTHER_LO 8
`define TGS_ST_OTHER_HI 14

// reset values
`define TGS_RST_CTRL 16'h0000
`define TGS_RST_MASK 16'h0000

// timing
`define TGS_CLK_PERIOD_NS 25
`define TGS_REPLY_TIME_NS 42700
`define TGS_REPLY_CYC ((`TGS_REPLY_TIME_NS) / (`TGS_CLK_PERIOD_NS))
`define TGS_IDLE_CYC 8'h35

// transition thresholds
`define TGS_OVERBAL_TRANS 3'h4
`define TGS_BUSY_TRANS 3'h7

`endif

//--- design/tgs_pkg.sv
// tgs_pkg: types shared by the telegram reception status block.
// assumes tgs_map.svh supplies all numeric constants.
package tgs_pkg;

	// evaluation sequence of one transfer
	typedef enum logic [2:0] {
		TGS_IDLE = 3'b000,
		TGS_WAIT_REPLY = 3'b001,
		TGS_RX_REPLY = 3'b010,
		TGS_FETCH = 3'b011,
		TGS_WRITE = 3'b100
	} tgs_fsm_t;

	// decoder events, all one-cycle pulses on core_clk_i
	typedef struct packed {
		logic request_frame_delimiter; // valid master frame seen
		logic reply_frame_delimiter; // valid slave delimiter seen
		logic frame_end; // slave frame finished
		logic crc_bad; // check sequence mismatch
		logic manchester_bad; // bad bit code
		logic length_bad; // frame length error
		logic dsample_first; // first of two double samples
		logic dsample_second; // second of two double samples
		logic [3:0] port; // port named by the master frame
	} tgs_dec_ev_t;

	// primary error flags of one transfer
	typedef struct packed {
		logic crc;
		logic signal_quality_error_flag;
		logic level_overbalance_flag;
		logic bus_busy_flag;
		logic telegram_error_flag;
		logic reply_timeout_flag;
	} tgs_flags_t;

	// whole state of the top module
	typedef struct packed {
		tgs_fsm_t fsm;
		logic write_anyway_enable;
		logic [15:0] sink_mask;
		logic [15:0] src_mask;
		logic [15:0] reply_limit;
		logic [15:0] reply_cnt;
		logic [3:0] port;
		logic port_sink;
		logic port_src;
		logic line_prev;
		logic [7:0] idle_cnt;
		logic idle;
		logic [2:0] trans_cnt;
		logic samp_first;
		logic quality_seen;
		logic crc;
		logic man;
		logic len;
		logic timeout_seen;
		tgs_flags_t flags;
		logic store;
		logic upd;
		logic frame_store;
		logic status_update;
		logic [15:0] rd_alt;
		logic rd_use_alt;
	} tgs_state_t;

endpackage

//--- design/tgs_sync.sv
// tgs_sync: three-stage synchroniser for line pins.
// assumes asynchronous inputs; a change is taken once stages two and
// three agree, so a single-cycle glitch in stage two is filtered.
`timescale 1ns/1ps
module tgs_sync
	import tgs_pkg::*;
#(
	parameter int unsigned WIDTH = 2
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	// all stages in one packed struct
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} tgs_sync_st_t;

	tgs_sync_st_t r;
	tgs_sync_st_t r_nxt;

	// stage one feeds only stage two
	always_comb
	begin
		r_nxt = r;
		r_nxt.s1 = async_i;
		r_nxt.s2 = r.s1;
		r_nxt.s3 = r.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (r.s2[i] == r.s3[i])
			begin
				r_nxt.q[i] = r.s3[i];
			end
		end
	end

	// idle line level is low
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
		end
		else
		begin
			r <= r_nxt;
		end
	end

	assign sync_o = r.q;
endmodule

//--- design/tgs_status_mem.sv
// tgs_status_mem: port status words, one per port.
// assumes port a is the host, port b the evaluation logic; b wins a
// same-cycle write collision. read data are registered.
`timescale 1ns/1ps
module tgs_status_mem
	import tgs_pkg::*;
#(
	parameter int unsigned DEPTH = 16,
	parameter int unsigned AW = 4
)
(
	input wire logic core_clk_i,
	input wire logic [AW-1:0] a_addr_i,
	input wire logic a_we_i,
	input wire logic [15:0] a_wdata_i,
	input wire logic a_use_alt_i,
	input wire logic [15:0] a_alt_i,
	output logic [15:0] a_q_o,
	input wire logic [AW-1:0] b_addr_i,
	input wire logic b_we_i,
	input wire logic [15:0] b_wdata_i,
	output logic [15:0] b_q_o
);
	logic [15:0] mem [DEPTH]; // contents set up by host software
	logic [15:0] a_q_r; // host read register
	logic [15:0] b_q_r; // evaluation read register

	// host read register also carries other registers' data, so the
	// top's read data come straight from a flop
	always_ff @(posedge core_clk_i)
	begin
		if (a_we_i && !(b_we_i && b_addr_i == a_addr_i))
		begin
			mem[a_addr_i] <= a_wdata_i;
		end
		if (b_we_i)
		begin
			mem[b_addr_i] <= b_wdata_i;
		end
		a_q_r <= a_use_alt_i ? a_alt_i : mem[a_addr_i];
		b_q_r <= mem[b_addr_i];
	end

	assign a_q_o = a_q_r;
	assign b_q_o = b_q_r;
endmodule

//--- design/tgs_rx_status.sv
// tgs_rx_status: per-port telegram reception status evaluation.
// assumes decoder events on core_clk_i and raw line pins a and b.
// Summary of operation
// - crc mismatch sets crc and telegram error
// - write-anyway sink stores crc-bad frame
// - double sample mismatch sets quality and telegram error
// - four transitions from idle set overbalance on a transfer with an error or timeout
// - seven transitions from idle set bus busy on a transfer with an error or timeout
// - bus busy updated for sources and sinks
// - bus busy implies telegram error or timeout
// - telegram error only after valid delimiter
// - telegram error from five causes, own flags
// - telegram error updated for sources and sinks
// - no reply delimiter in time sets timeout
// - flags rewritten each transfer, never accumulated
// - page pointer kept when frame not stored
// - primary flags follow the active line
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "tgs_map.svh"
module tgs_rx_status
	import tgs_pkg::*;
#(
	parameter logic [7:0] IDLE_CYC = `TGS_IDLE_CYC,
	parameter logic [15:0] REPLY_CYC = 16'(`TGS_REPLY_CYC)
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic line_a_i,
	input wire logic line_b_i,
	input wire logic active_line_select_i,
	input wire tgs_dec_ev_t dec_i,
	output logic frame_store_o,
	output logic status_update_o,
	output tgs_flags_t flags_o
);
	tgs_state_t r; // whole block state
	tgs_state_t r_nxt; // its next value
	logic [1:0] line_sync; // {a, b} after synchroniser
	logic line_act; // active line level
	logic [15:0] host_q; // host read data from memory flop
	logic [15:0] word_q; // stored word of current port
	logic [15:0] word_nxt; // rewritten status word
	logic mem_we; // evaluation write strobe
	tgs_flags_t fl; // flags of current transfer
	logic bad; // any error of current transfer
	logic store; // frame goes to traffic memory
	logic line_err; // error in received data

	// true when the address falls on a port status word
	function automatic logic is_stat(input logic [7:0] a);
		return a >= `TGS_A_STAT_BASE && a <= `TGS_A_STAT_LAST;
	endfunction

	// true when the port bit is set in a mask
	function automatic logic port_in(input logic [15:0] m,
		input logic [3:0] p);
		return m[p];
	endfunction

	// pins cross into the clock domain here
	tgs_sync #(
		.WIDTH(2)
	) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i({line_a_i, line_b_i}),
		.sync_o(line_sync)
	);

	// primary flags watch only the selected line
	assign line_act = active_line_select_i ? line_sync[1] : line_sync[0];

	// status words; host on port a, evaluation on port b
	tgs_status_mem #(
		.DEPTH(16),
		.AW(4)
	) u_mem (
		.core_clk_i(core_clk_i),
		.a_addr_i(reg_addr_i[3:0]),
		.a_we_i(reg_wr_i && is_stat(reg_addr_i)),
		.a_wdata_i(reg_wdata_i),
		.a_use_alt_i(r_nxt.rd_use_alt),
		.a_alt_i(r_nxt.rd_alt),
		.a_q_o(host_q),
		.b_addr_i(r.port),
		.b_we_i(mem_we),
		.b_wdata_i(word_nxt),
		.b_q_o(word_q)
	);

	// flag evaluation from what the transfer collected
	always_comb
	begin
		fl = '0;
		line_err = r.crc || r.man || r.len || r.quality_seen;
		bad = line_err || r.timeout_seen;
		fl.crc = r.crc;
		fl.signal_quality_error_flag = r.quality_seen;
		// overbalance never after a clean transfer
		fl.level_overbalance_flag = bad &&
			r.trans_cnt >= `TGS_OVERBAL_TRANS;
		// only reached after a valid request delimiter
		fl.telegram_error_flag = line_err ||
			fl.level_overbalance_flag;
		fl.reply_timeout_flag = r.timeout_seen;
		// tied to error or timeout, so never after success
		fl.bus_busy_flag = r.trans_cnt >= `TGS_BUSY_TRANS &&
			(fl.telegram_error_flag || r.timeout_seen);
		// only sinks store; write-anyway lets a crc-bad frame in
		store = r.port_sink && !r.port_src && !r.timeout_seen &&
			(!bad || (r.write_anyway_enable && r.crc));
	end

	// rewrite of the word: own bits replaced, redundant-line bits kept,
	// reserved bits written as zero
	always_comb
	begin
		word_nxt = '0;
		word_nxt[`TGS_ST_OTHER_HI:`TGS_ST_OTHER_LO] =
			word_q[`TGS_ST_OTHER_HI:`TGS_ST_OTHER_LO];
		// pointer flips only when data were stored
		word_nxt[`TGS_ST_PAGE] = word_q[`TGS_ST_PAGE] ^ r.store;
		word_nxt[`TGS_ST_CRC] = r.flags.crc;
		word_nxt[`TGS_ST_QUALITY] = r.flags.signal_quality_error_flag;
		word_nxt[`TGS_ST_OVERBAL] = r.flags.level_overbalance_flag;
		word_nxt[`TGS_ST_BUSY] = r.flags.bus_busy_flag;
		word_nxt[`TGS_ST_TELERR] = r.flags.telegram_error_flag;
		word_nxt[`TGS_ST_TIMEOUT] = r.flags.reply_timeout_flag;
		mem_we = r.fsm == TGS_WRITE;
	end

	// next state of the whole block
	always_comb
	begin
		r_nxt = r;
		r_nxt.frame_store = 1'b0;
		r_nxt.status_update = 1'b0;

		// register writes
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				`TGS_A_CTRL: r_nxt.write_anyway_enable =
					reg_wdata_i[`TGS_CTRL_WRANY_BIT];
				`TGS_A_SINK: r_nxt.sink_mask = reg_wdata_i;
				`TGS_A_SRC: r_nxt.src_mask = reg_wdata_i;
				`TGS_A_REPLY: r_nxt.reply_limit = reg_wdata_i;
				default: ; // status words, read-only live word or unmapped
			endcase
		end

		// register reads; memory flop picks alt data off the words
		r_nxt.rd_use_alt = !is_stat(reg_addr_i) || !reg_rd_i;
		r_nxt.rd_alt = '0;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				`TGS_A_CTRL: r_nxt.rd_alt[`TGS_CTRL_WRANY_BIT] =
					r.write_anyway_enable;
				`TGS_A_SINK: r_nxt.rd_alt = r.sink_mask;
				`TGS_A_SRC: r_nxt.rd_alt = r.src_mask;
				`TGS_A_REPLY: r_nxt.rd_alt = r.reply_limit;
				`TGS_A_LIVE: r_nxt.rd_alt = {3'h0, r.idle, r.port,
					1'b0, r.trans_cnt, 1'b0, r.fsm};
				default: r_nxt.rd_alt = '0; // unmapped reads zero
			endcase
		end

		// transition counting; restarts on the first edge from idle
		r_nxt.line_prev = line_act;
		if (line_act != r.line_prev)
		begin
			r_nxt.idle_cnt = '0;
			r_nxt.idle = 1'b0;
			if (r.idle)
			begin
				r_nxt.trans_cnt = 3'h1;
			end
			else if (r.trans_cnt != 3'h7)
			begin
				r_nxt.trans_cnt = r.trans_cnt + 3'h1; // saturate
			end
		end
		else if (r.idle_cnt >= IDLE_CYC - 8'h01)
		begin
			r_nxt.idle = 1'b1;
		end
		else
		begin
			r_nxt.idle_cnt = r.idle_cnt + 8'h01;
		end

		// double sampling: compare second sample with first
		if (dec_i.dsample_first)
		begin
			r_nxt.samp_first = line_act;
		end
		if (dec_i.dsample_second && line_act != r.samp_first &&
			(r.fsm == TGS_WAIT_REPLY || r.fsm == TGS_RX_REPLY))
		begin
			r_nxt.quality_seen = 1'b1;
		end

		unique case (r.fsm)
			TGS_IDLE:
			begin
				// only active ports, source or sink, are evaluated
				if (dec_i.request_frame_delimiter &&
					(port_in(r.sink_mask, dec_i.port) ||
					port_in(r.src_mask, dec_i.port)))
				begin
					r_nxt.fsm = TGS_WAIT_REPLY;
				end
			end
			TGS_WAIT_REPLY:
			begin
				// a new request while waiting restarts, no update
				if (dec_i.request_frame_delimiter)
				begin
					r_nxt.fsm = (port_in(r.sink_mask, dec_i.port) ||
						port_in(r.src_mask, dec_i.port)) ?
						TGS_WAIT_REPLY : TGS_IDLE;
				end
				else if (dec_i.reply_frame_delimiter)
				begin
					r_nxt.fsm = TGS_RX_REPLY;
				end
				else if (r.reply_cnt >= r.reply_limit - 16'h0001)
				begin
					r_nxt.timeout_seen = 1'b1;
					r_nxt.fsm = TGS_FETCH;
				end
				else
				begin
					r_nxt.reply_cnt = r.reply_cnt + 16'h0001;
				end
			end
			TGS_RX_REPLY:
			begin
				if (dec_i.frame_end)
				begin
					r_nxt.crc = dec_i.crc_bad;
					r_nxt.man = dec_i.manchester_bad;
					r_nxt.len = dec_i.length_bad;
					r_nxt.fsm = TGS_FETCH;
				end
			end
			TGS_FETCH:
			begin
				// memory read of the port word lands next cycle
				r_nxt.flags = fl;
				r_nxt.store = store;
				r_nxt.fsm = TGS_WRITE;
			end
			TGS_WRITE:
			begin
				// every transfer overwrites all own flags
				r_nxt.status_update = 1'b1;
				r_nxt.frame_store = r.store;
				r_nxt.fsm = TGS_IDLE;
			end
			default: r_nxt.fsm = TGS_IDLE; // illegal codes recover
		endcase

		// new transfer: latch port, clear what the last one left
		if (dec_i.request_frame_delimiter &&
			(r.fsm == TGS_IDLE || r.fsm == TGS_WAIT_REPLY))
		begin
			r_nxt.port = dec_i.port;
			r_nxt.port_sink = port_in(r.sink_mask, dec_i.port);
			r_nxt.port_src = port_in(r.src_mask, dec_i.port);
			r_nxt.reply_cnt = '0;
			r_nxt.quality_seen = 1'b0;
			r_nxt.crc = 1'b0;
			r_nxt.man = 1'b0;
			r_nxt.len = 1'b0;
			r_nxt.timeout_seen = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
			r.fsm <= TGS_IDLE;
			// only the enable bit of the control reset word is kept
			r.write_anyway_enable <=
				1'((`TGS_RST_CTRL) >> `TGS_CTRL_WRANY_BIT);
			r.sink_mask <= `TGS_RST_MASK;
			r.src_mask <= `TGS_RST_MASK;
			r.reply_limit <= REPLY_CYC;
			r.rd_use_alt <= 1'b1;
		end
		else
		begin
			r <= r_nxt;
		end
	end

	assign reg_rdata_o = host_q;
	assign frame_store_o = r.frame_store;
	assign status_update_o = r.status_update;
	assign flags_o = r.flags;
endmodule

//--- sim/tgs_rx_status_assertions.sv
// checker: flag relations and event timing of tgs_rx_status.
// assumes a bind to every instance of the top module.
`timescale 1ns/1ps
module tgs_rx_status_assertions
	import tgs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire tgs_dec_ev_t dec_i,
	input wire logic frame_store_o,
	input wire logic status_update_o,
	input wire tgs_flags_t flags_o
);
	// single domain, so one clocking and one disable
	default clocking dcb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	crc_error_a: assert property (
		flags_o.crc |-> flags_o.telegram_error_flag)
		else $error("crc without telegram error");
	quality_error_a: assert property (
		flags_o.signal_quality_error_flag |-> flags_o.telegram_error_flag)
		else $error("quality error without telegram error");
	overbal_error_a: assert property (
		flags_o.level_overbalance_flag |-> flags_o.telegram_error_flag)
		else $error("overbalance without telegram error");
	busy_cause_a: assert property (
		flags_o.bus_busy_flag |->
		flags_o.telegram_error_flag || flags_o.reply_timeout_flag)
		else $error("bus busy without cause");
	busy_overbal_a: assert property (
		flags_o.bus_busy_flag |-> flags_o.level_overbalance_flag)
		else $error("bus busy without overbalance");
	// flags settle one cycle ahead of the update pulse
	flags_hold_a: assert property (
		$changed(flags_o) |=> status_update_o)
		else $error("flags moved without update");
	crc_report_a: assert property (
		dec_i.frame_end && dec_i.crc_bad |->
		##3 (!status_update_o || flags_o.crc))
		else $error("crc not reported");
	store_upd_a: assert property (
		frame_store_o |-> status_update_o && !flags_o.reply_timeout_flag)
		else $error("stray store");
	store_err_a: assert property (
		frame_store_o && flags_o.telegram_error_flag |-> flags_o.crc)
		else $error("bad frame stored");
endmodule
bind tgs_rx_status tgs_rx_status_assertions i_chk (.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i), .dec_i(dec_i), .frame_store_o(frame_store_o),
	.status_update_o(status_update_o), .flags_o(flags_o));

//--- sim/tgs_bus_model.sv
// tgs_bus_model: other stations on the two lines plus their decoder events.
// assumes the bench calls xfer once the lines have gone idle.
`timescale 1ns/1ps
module tgs_bus_model
	import tgs_pkg::*;
(
	input wire logic core_clk_i,
	output logic line_a_o,
	output logic line_b_o,
	output tgs_dec_ev_t dec_o
);
	initial
	begin
		line_a_o = 1'b0;
		line_b_o = 1'b0;
		dec_o = '0;
	end
	// one-cycle decoder event
	task automatic pulse(input tgs_dec_ev_t ev);
		@(posedge core_clk_i);
		dec_o <= ev;
		@(posedge core_clk_i);
		dec_o <= '0;
	endtask
	// e = {crc, man, len, quality}; m = lines that toggle; to = no reply
	task automatic xfer(input logic [3:0] p, input logic [3:0] e,
		input int n, input logic [1:0] m, input bit to);
		tgs_dec_ev_t ev;
		// levels held 3 cycles so the synchroniser keeps each one
		repeat (n)
		begin
			@(posedge core_clk_i);
			line_a_o <= line_a_o ^ m[0];
			line_b_o <= line_b_o ^ m[1];
			repeat (2) @(posedge core_clk_i);
		end
		repeat (6) @(posedge core_clk_i);
		ev = '0;
		ev.request_frame_delimiter = 1'b1;
		ev.port = p;
		pulse(ev);
		if (!to)
		begin
			ev = '0;
			ev.dsample_first = 1'b1;
			pulse(ev);
			// level change between samples gives the quality error
			if (e[0])
			begin
				@(posedge core_clk_i);
				line_a_o <= ~line_a_o;
				line_b_o <= ~line_b_o;
				repeat (5) @(posedge core_clk_i);
			end
			ev = '0;
			ev.dsample_second = 1'b1;
			pulse(ev);
			ev = '0;
			ev.reply_frame_delimiter = 1'b1;
			pulse(ev);
			repeat (6) @(posedge core_clk_i);
			ev = '0;
			ev.frame_end = 1'b1;
			{ev.crc_bad, ev.manchester_bad, ev.length_bad} = e[3:1];
			pulse(ev);
		end
	endtask
endmodule

//--- sim/tgs_rx_status_test.sv
// tgs_rx_status_test: corner and random telegrams, flags and status words.
// assumes tgs_bus_model as the far side and the bound checker.
`timescale 1ns/1ps
`include "tgs_map.svh"
module tgs_rx_status_test
	import tgs_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic active_line_select_i = 1'b1;
	logic [15:0] reg_rdata_o;
	logic line_a;
	logic line_b;
	tgs_dec_ev_t dec;
	logic frame_store_o;
	logic status_update_o;
	tgs_flags_t flags_o;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	int last_n = 0; // active-line transitions of the latest reception
	// port 2 sink, 5 source, 9 both, 12 inactive
	logic [15:0] sink = 16'h0204;
	logic [15:0] src = 16'h0220;
	logic [3:0] ports [3] = '{4'h2, 4'h5, 4'h9};
	// {port, errs, transitions, lines, timeout, write-any, select}
	// one-line toggles stay even so both lines end at one level and a
	// later select change shows no false transition
	logic [15:0] tab [12] = '{16'h2019, 16'h2819, 16'h281b, 16'h2179,
		16'h20f9, 16'h2899, 16'h54f9, 16'h90fd, 16'h201d, 16'h28c8,
		16'hc019, 16'h981b};
	always #12.5 core_clk_i = ~core_clk_i;
	tgs_rx_status #(.IDLE_CYC(8'h08)) i_tgs_rx_status (.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.line_a_i(line_a), .line_b_i(line_b),
		.active_line_select_i(active_line_select_i), .dec_i(dec),
		.frame_store_o(frame_store_o), .status_update_o(status_update_o),
		.flags_o(flags_o));
	tgs_bus_model i_tgs_bus_model (.core_clk_i(core_clk_i), .line_a_o(line_a),
		.line_b_o(line_b), .dec_o(dec));
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		d = reg_rdata_o;
	endtask
	// expected flags from causes and transitions on the active line
	function automatic tgs_flags_t expf(logic [3:0] e, int n, bit to);
		tgs_flags_t f;
		f = '0;
		f.crc = e[3];
		f.signal_quality_error_flag = e[0];
		f.reply_timeout_flag = to;
		f.level_overbalance_flag = n >= 4 && (|e || to);
		f.telegram_error_flag = |e || f.level_overbalance_flag;
		f.bus_busy_flag = n >= 7 && (f.telegram_error_flag || to);
		return f;
	endfunction
	task automatic run(input logic [15:0] w);
		logic [15:0] w0;
		logic [15:0] w1;
		logic [3:0] p;
		logic [3:0] e;
		tgs_flags_t f;
		bit st;
		int k;
		int n;
		p = w[15:12];
		e = w[2] ? 4'h0 : w[11:8];
		wr(`TGS_A_CTRL, {15'h0000, w[1]});
		active_line_select_i <= w[0];
		rd(`TGS_A_STAT_BASE + {4'h0, p}, w0);
		n = (w[0] ? w[3] : w[4]) ? int'(w[7:5]) : 0;
		// the quality toggle comes after the line went idle, so it
		// starts a fresh count; a quiet line keeps the last count
		if (e[0])
			n = 1;
		else if (n == 0)
			n = last_n;
		last_n = n;
		f = expf(e, n, w[2]);
		st = sink[p] && !src[p] && !w[2] && (!f.telegram_error_flag ||
			(w[1] && e[3]));
		i_tgs_bus_model.xfer(p, e, int'(w[7:5]), w[4:3], w[2]);
		k = 0;
		do
		begin
			@(negedge core_clk_i);
			k++;
		end while (status_update_o !== 1'b1 && k < 60);
		if (!(sink[p] || src[p]))
			chk("inactive update", 16'(k), 16'h003c);
		else
		begin
			chk("flags", 16'(flags_o), 16'(f));
			chk("store", 16'(frame_store_o), 16'(st));
		end
		repeat (16) @(posedge core_clk_i);
		rd(`TGS_A_STAT_BASE + {4'h0, p}, w1);
		if (sink[p] || src[p])
			chk("status word", 16'(w1[6:0]), 16'({w0[6] ^ st, f}));
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, well above some 2600 cycles of traffic
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			results();
		end
	end
	initial
	begin
		logic [15:0] w;
		int i;
		w = 16'($urandom(32'h8fa0_6136));
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		rd(`TGS_A_REPLY, w);
		chk("reply limit", w, 16'h06ac);
		rd(8'h20, w);
		chk("unmapped", w, 16'h0000);
		wr(`TGS_A_REPLY, 16'h0014);
		wr(`TGS_A_SINK, sink);
		wr(`TGS_A_SRC, src);
		rd(`TGS_A_SINK, w);
		chk("sink mask", w, sink);
		for (i = 0; i < 16; i++)
			wr(`TGS_A_STAT_BASE + 8'(i), 16'h0000);
		// corner table first, then random telegrams
		for (i = 0; i < 40; i++)
		begin
			if (i < 12)
				w = tab[i];
			else
				w = {ports[$urandom % 3], 4'($urandom), 3'($urandom), 2'b11,
					$urandom % 4 == 0, 1'($urandom), 1'b1};
			run(w);
		end
		results();
	end
endmodule
